// [hdl/usb_err_pkg.sv]
// Constants, types and address decode for the USB error interrupt block.
// Assumes a 32-bit register port with byte addresses, one word per register.
package usb_err_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 8;

    // Register bases; each has clear, set and invert aliases above it
    localparam logic [7:0] OFS_ERR_FLAG = 8'h00;
    localparam logic [7:0] OFS_ERR_MASK = 8'h10;
    localparam logic [7:0] OFS_MOD_EN   = 8'h20;
    localparam logic [7:0] OFS_MOD_FLAG = 8'h30;

    localparam logic [3:0] ALIAS_BASE = 4'h0;
    localparam logic [3:0] ALIAS_CLR  = 4'h4;
    localparam logic [3:0] ALIAS_SET  = 4'h8;
    localparam logic [3:0] ALIAS_INV  = 4'hC;
    localparam logic [7:0] BASE_MASK  = 8'hF0;

    // Error flag and enable positions, shared layout
    localparam int BIT_STUFFING  = 7;
    localparam int BIT_MATRIX    = 6;
    localparam int BIT_XFER_ENG  = 5;
    localparam int BIT_TURNAROUND = 4;
    localparam int BIT_FIELD_SIZE = 3;
    localparam int BIT_DATA_CRC  = 2;
    localparam int BIT_TOKEN_FRAME = 1;
    localparam int BIT_PACKET_ID = 0;

    localparam int MOD_ERR_EN_BIT = 1;
    localparam int MOD_FLAG_BIT   = 0;

    // Implemented bits and reset values
    localparam logic [7:0] IMPL_ALL      = 8'hFF;
    localparam logic [7:0] IMPL_MOD_EN   = 8'h02;
    localparam logic [7:0] IMPL_MOD_FLAG = 8'h01;
    localparam logic [7:0] RST_ERR_FLAG  = 8'h00;
    localparam logic [7:0] RST_ERR_MASK  = 8'h00;
    localparam logic [7:0] RST_MOD_EN    = 8'h00;
    localparam logic [7:0] RST_MOD_FLAG  = 8'h00;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_CLR,
        OP_SET,
        OP_INV
    } write_op_type;

    function automatic write_op_type alias_op(input logic [ADDR_W-1:0] addr);
        write_op_type op;
        op = OP_WRITE;
        unique case (addr[3:0])
            ALIAS_CLR: op = OP_CLR;
            ALIAS_SET: op = OP_SET;
            ALIAS_INV: op = OP_INV;
            default:   op = OP_WRITE;
        endcase
        return op;
    endfunction

    function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] base);
        return ((addr & BASE_MASK) == base) && (addr[1:0] == 2'b00);
    endfunction

endpackage

// [hdl/alias_reg.sv]
// One 8-bit register with write, clear, set and invert access.
// Assumes the caller decodes the address; hardware sets override software.
`timescale 1ns/1ns
module alias_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] IMPL      = 8'hFF,
    parameter bit         W1C_BASE  = 1'b0
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wr_i,
    input  wire usb_err_pkg::write_op_type op_i,
    input  wire logic [7:0]                wdata_i,
    input  wire logic [7:0]                hw_set_i,
    output logic      [7:0]                value_o
);

    typedef struct packed {
        logic [7:0] value;
    } state_type;

    state_type cur_ff;
    state_type nxt_state;

    always_comb begin
        nxt_state = cur_ff;
        if (wr_i) begin
            unique case (op_i)
                usb_err_pkg::OP_WRITE: nxt_state.value = W1C_BASE ?
                    (cur_ff.value & ~wdata_i) : wdata_i;
                usb_err_pkg::OP_CLR:   nxt_state.value = cur_ff.value & ~wdata_i; // [R12]
                usb_err_pkg::OP_SET:   nxt_state.value = cur_ff.value | wdata_i;  // [R12]
                usb_err_pkg::OP_INV:   nxt_state.value = cur_ff.value ^ wdata_i;  // [R12]
            endcase
        end
        // Set after clear, so an event in the clearing cycle survives
        nxt_state.value = (nxt_state.value | hw_set_i) & IMPL;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff.value <= RESET_VAL;
        end else begin
            cur_ff <= nxt_state;
        end
    end

    assign value_o = cur_ff.value;

endmodule

// [hdl/err_gate.sv]
// Enable gating of the eight error flags into one combined error level.
// Assumes flags and enables share one bit layout; purely combinational.
`timescale 1ns/1ns
module err_gate (
    input  wire logic [7:0] flag_i,
    input  wire logic [7:0] enable_i,
    output logic      [7:0] gated_o,
    output logic            combined_o
);

    genvar g;
    generate
        for (g = 0; g < usb_err_pkg::FLAG_W; g++) begin : g_gate
            // Each source passes only with its enable at one
            assign gated_o[g] = flag_i[g] & enable_i[g]; // [R01] [R02] [R03] [R04] [R05] [R06] [R09]
        end
    endgenerate

    assign combined_o = |gated_o; // [R13]

endmodule

// [hdl/usb_error_irq.sv]
// USB error interrupt enable block: error flags, their enables, the
// module-level error enable and the module interrupt flag.
// Assumes error pulses and mode come from logic on clk_i.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Function
// R01 - Bit stuff error reaches error interrupt only with enable bit 7 set.
// R02 - Bus matrix error passes only with enable bit 6 set.
// R03 - Transfer engine error passes only with enable bit 5 set.
// R04 - Turnaround time-out error passes only with enable bit 4 set.
// R05 - Data field size error passes only with enable bit 3 set.
// R06 - Data CRC failure passes only with enable bit 2 set.
// R07 - Device mode: bit 1 enables the token CRC error.
// R08 - Host mode: the same bit 1 enables the frame end error.
// R09 - Packet id check failure passes only with enable bit 0 set.
// R10 - Only low eight mask bits exist, reset zero; upper bits read zero.
// R11 - Combined error sets module flag only while module error enable is set.
// R12 - Clear, set and invert aliases at plus 4, 8 and 12.
// R13 - Combined error is OR of each flag AND its enable, every cycle.
// R14 - Software sets enables first and clears stale flags before changes.
module usb_error_irq (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        host_mode_i,
    input  wire logic [7:0]  err_pulse_i,
    input  wire logic        frame_end_err_i,
    output logic      [7:0]  err_flag_o,
    output logic             combined_err_o,
    output logic             module_irq_flag_o,
    output logic             irq_o
);

    //////////////////////////////////////////////////////////////////////////
    // Address decode

    usb_err_pkg::write_op_type op;
    logic                      wr_flag;
    logic                      wr_mask;
    logic                      wr_en;
    logic                      wr_mflag;

    assign op       = usb_err_pkg::alias_op(addr_i);
    assign wr_flag  = wr_i & usb_err_pkg::hits(addr_i, usb_err_pkg::OFS_ERR_FLAG);
    assign wr_mask  = wr_i & usb_err_pkg::hits(addr_i, usb_err_pkg::OFS_ERR_MASK);
    assign wr_en    = wr_i & usb_err_pkg::hits(addr_i, usb_err_pkg::OFS_MOD_EN);
    assign wr_mflag = wr_i & usb_err_pkg::hits(addr_i, usb_err_pkg::OFS_MOD_FLAG);

    //////////////////////////////////////////////////////////////////////////
    // Error flag sources

    logic [7:0] err_set;

    always_comb begin
        err_set = err_pulse_i;
        // One flag position shared by two mode-dependent errors
        err_set[usb_err_pkg::BIT_TOKEN_FRAME] = host_mode_i ?
            frame_end_err_i :                                  // [R08]
            err_pulse_i[usb_err_pkg::BIT_TOKEN_FRAME];         // [R07]
    end

    //////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] err_flag;
    logic [7:0] err_mask;
    logic [7:0] mod_en;
    logic [7:0] mod_flag;
    logic       combined;
    logic [7:0] mflag_set;

    // Sticky flags; a plain write of ones clears them
    alias_reg #(
        .RESET_VAL (usb_err_pkg::RST_ERR_FLAG),
        .IMPL      (usb_err_pkg::IMPL_ALL),
        .W1C_BASE  (1'b1)
    ) u_err_flag (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wr_i     (wr_flag),
        .op_i     (op),
        .wdata_i  (wdata_i[7:0]),
        .hw_set_i (err_set),
        .value_o  (err_flag)
    );

    alias_reg #(
        .RESET_VAL (usb_err_pkg::RST_ERR_MASK),
        .IMPL      (usb_err_pkg::IMPL_ALL),
        .W1C_BASE  (1'b0)
    ) u_err_mask (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wr_i     (wr_mask),
        .op_i     (op),
        .wdata_i  (wdata_i[7:0]),  // [R10]
        .hw_set_i (8'h00),
        .value_o  (err_mask)
    );

    alias_reg #(
        .RESET_VAL (usb_err_pkg::RST_MOD_EN),
        .IMPL      (usb_err_pkg::IMPL_MOD_EN),
        .W1C_BASE  (1'b0)
    ) u_mod_en (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wr_i     (wr_en),
        .op_i     (op),
        .wdata_i  (wdata_i[7:0]),
        .hw_set_i (8'h00),
        .value_o  (mod_en)
    );

    err_gate u_gate (
        .flag_i     (err_flag),
        .enable_i   (err_mask),
        .gated_o    (),
        .combined_o (combined)
    );

    always_comb begin
        mflag_set = 8'h00;
        mflag_set[usb_err_pkg::MOD_FLAG_BIT] =
            combined & mod_en[usb_err_pkg::MOD_ERR_EN_BIT]; // [R11]
    end

    // Sticky module flag; stays set until software clears it
    alias_reg #(
        .RESET_VAL (usb_err_pkg::RST_MOD_FLAG),
        .IMPL      (usb_err_pkg::IMPL_MOD_FLAG),
        .W1C_BASE  (1'b1)
    ) u_mod_flag (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wr_i     (wr_mflag),
        .op_i     (op),
        .wdata_i  (wdata_i[7:0]),
        .hw_set_i (mflag_set),
        .value_o  (mod_flag)
    );

    //////////////////////////////////////////////////////////////////////////
    // Read port, data valid only in the cycle after the strobe

    typedef struct packed {
        logic [31:0] rdata;
    } state_type;

    state_type cur_ff;
    state_type nxt_state;

    always_comb begin
        nxt_state = '0;
        if (rd_i && addr_i[3:0] == usb_err_pkg::ALIAS_BASE) begin
            unique case (addr_i)
                usb_err_pkg::OFS_ERR_FLAG: nxt_state.rdata = {24'h00_0000, err_flag};
                usb_err_pkg::OFS_ERR_MASK: nxt_state.rdata = {24'h00_0000, err_mask}; // [R10]
                usb_err_pkg::OFS_MOD_EN:   nxt_state.rdata = {24'h00_0000, mod_en};
                usb_err_pkg::OFS_MOD_FLAG: nxt_state.rdata = {24'h00_0000, mod_flag};
                default:                   nxt_state.rdata = usb_err_pkg::RDATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff.rdata <= usb_err_pkg::RDATA_ZERO;
        end else begin
            cur_ff <= nxt_state;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata_o           = cur_ff.rdata;
    assign err_flag_o        = err_flag;
    assign combined_err_o    = combined;
    assign module_irq_flag_o = mod_flag[usb_err_pkg::MOD_FLAG_BIT];
    assign irq_o             = mod_flag[usb_err_pkg::MOD_FLAG_BIT];

endmodule

// [bench/usb_err_source.sv]
// Model of the protocol engine that raises error events.
// Assumes the bench calls its tasks; pulses are one clock long.
`timescale 1ns/1ns
module usb_err_source (
    input  wire logic       clk_i,
    output logic            host_mode_o,
    output logic [7:0]      err_pulse_o,
    output logic            frame_end_o
);
    initial begin
        host_mode_o = 1'b0;
        err_pulse_o = 8'h00;
        frame_end_o = 1'b0;
    end
    //////////////////////////////
    // Single-cycle events, so a stuck pulse cannot hide a clear
    task automatic fire(input logic [7:0] bits, input logic fe);
        @(posedge clk_i);
        err_pulse_o <= bits;
        frame_end_o <= fe;
        @(posedge clk_i);
        err_pulse_o <= 8'h00;
        frame_end_o <= 1'b0;
    endtask
    task automatic set_mode(input logic host);
        @(posedge clk_i);
        host_mode_o <= host;
    endtask
endmodule

// [bench/usb_error_irq_sva.sv]
// Checker for the USB error interrupt block, bound to its top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module usb_error_irq_sva (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [31:0] rdata_o,
    input  wire logic        host_mode_i,
    input  wire logic [7:0]  err_pulse_i,
    input  wire logic        frame_end_err_i,
    input  wire logic [7:0]  err_flag_o,
    input  wire logic        combined_err_o,
    input  wire logic        module_irq_flag_o,
    input  wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    //////////////////////////////
    a_stuff_flag: assert property (err_pulse_i[7] |=> err_flag_o[7])
        else $error("stuffing flag not set");
    a_other_flags: assert property ((err_pulse_i & 8'hFD) != 8'h00 |=>
        (err_flag_o & $past(err_pulse_i) & 8'hFD) == ($past(err_pulse_i) & 8'hFD))
        else $error("error flag not set");
    a_token_dev: assert property (!host_mode_i && err_pulse_i[1] |=> err_flag_o[1])
        else $error("token flag not set");
    a_frame_host: assert property (host_mode_i && frame_end_err_i |=> err_flag_o[1])
        else $error("frame end flag not set");
    a_comb_cause: assert property (combined_err_o |-> err_flag_o != 8'h00)
        else $error("combined error without flag");
    a_upper_zero: assert property (rdata_o[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("read data outside read slot");
    a_irq_cause: assert property ($rose(module_irq_flag_o) |->
        $past(combined_err_o) || $past(wr_i))
        else $error("module flag rose without cause");
    a_reset_clear: assert property ($fell(rst_i) |-> !irq_o && err_flag_o == 8'h00)
        else $error("state not cleared by reset");
    c_irq: cover property ($rose(irq_o));
    c_host: cover property (combined_err_o && host_mode_i);
    c_read: cover property (rd_i ##1 rdata_o != 32'h0000_0000);
endmodule

bind usb_error_irq usb_error_irq_sva usb_error_irq_sva_i (.clk_i, .rst_i, .wr_i, .rd_i,
    .rdata_o, .host_mode_i, .err_pulse_i, .frame_end_err_i, .err_flag_o, .combined_err_o,
    .module_irq_flag_o, .irq_o);

// [bench/usb_error_irq_bench.sv]
// Self-checking bench for the USB error interrupt block.
// Assumes the error source model drives the event inputs.
`timescale 1ns/1ns
module usb_error_irq_bench;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [31:0] ONE  = 32'h0000_0001;
    localparam logic [31:0] FF   = 32'h0000_00FF;
    localparam logic [7:0]  FLG  = usb_err_pkg::OFS_ERR_FLAG;
    localparam logic [7:0]  MSK  = usb_err_pkg::OFS_ERR_MASK;
    localparam logic [7:0]  MEN  = usb_err_pkg::OFS_MOD_EN;
    localparam logic [7:0]  MFL  = usb_err_pkg::OFS_MOD_FLAG;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = ZERO;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        rd_seen = 1'b0;
    logic [31:0] rdata_o;
    logic        host_mode;
    logic [7:0]  err_pulse;
    logic        frame_end;
    logic [7:0]  err_flag_o;
    logic        combined_err_o;
    logic        module_irq_flag_o;
    logic        irq_o;
    logic [31:0] exp_q[$];
    logic [31:0] r;
    int          bad_count = 0;
    int          num_checks = 0;

    always #10 clk_i = ~clk_i;

    usb_error_irq usb_error_irq_i (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .host_mode_i(host_mode), .err_pulse_i(err_pulse), .frame_end_err_i(frame_end),
        .err_flag_o, .combined_err_o, .module_irq_flag_o, .irq_o);
    usb_err_source usb_err_source_i (.clk_i, .host_mode_o(host_mode),
        .err_pulse_o(err_pulse), .frame_end_o(frame_end));
    //////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] e);
        num_checks++;
        if (got !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Read data is valid only in the slot after the strobe
    always @(posedge clk_i) begin
        if (rd_seen)
            cmp(rdata_o, exp_q.pop_front());
        rd_seen <= rd_i;
    end
    //////////////////////////////
    initial begin
        r = $urandom(32'h2f98_8530);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++)
            rd(8'(i * 16), ZERO);
        rd(8'h40, ZERO);
        rd(8'h11, ZERO);
        $display("test reset done");
        r = $urandom();
        wr(MSK, r);
        rd(MSK, r & FF);
        wr(MSK, 32'h0000_00F0);
        wr(MSK | 8'h08, 32'h0000_000F);
        rd(MSK, FF);
        wr(MSK | 8'h04, 32'h0000_0081);
        rd(MSK, 32'h0000_007E);
        wr(MSK | 8'h0C, FF);
        rd(MSK, 32'h0000_0081);
        $display("test alias done");
        for (int k = 0; k < 8; k++) begin
            wr(FLG, FF);
            wr(MSK, ONE << k);
            usb_err_source_i.fire(~(8'h01 << k), 1'b0);
            #1 cmp(32'(combined_err_o), ZERO);
            usb_err_source_i.fire(8'h01 << k, 1'b0);
            #1 cmp(32'(combined_err_o), ONE);
            rd(FLG, FF);
        end
        $display("test gating done");
        usb_err_source_i.set_mode(1'b1);
        wr(FLG, FF);
        wr(MSK, 32'h0000_0002);
        usb_err_source_i.fire(8'h02, 1'b0);
        rd(FLG, ZERO);
        usb_err_source_i.fire(8'h00, 1'b1);
        #1 cmp(32'(combined_err_o), ONE);
        usb_err_source_i.set_mode(1'b0);
        wr(FLG, FF);
        usb_err_source_i.fire(8'h00, 1'b1);
        rd(FLG, ZERO);
        $display("test mode done");
        wr(FLG, FF);
        wr(MSK, 32'h0000_0080);
        usb_err_source_i.fire(8'h80, 1'b0);
        repeat (3) @(posedge clk_i);
        #1 cmp(32'(irq_o), ZERO);
        wr(MEN, 32'h0000_0002);
        @(posedge clk_i);
        #1 cmp(32'(irq_o), ONE);
        cmp(32'(module_irq_flag_o), ONE);
        rd(MFL, ONE);
        wr(MSK | 8'h04, 32'h0000_0080);
        wr(MFL, ONE);
        @(posedge clk_i);
        #1 cmp(32'(irq_o), ZERO);
        wr(MEN, ZERO);
        $display("test irq done");
        wr(MFL | 8'h08, ONE);
        #1 cmp(32'(irq_o), ONE);
        wr(MFL | 8'h04, ONE);
        #1 cmp(32'(module_irq_flag_o), ZERO);
        wr(FLG | 8'h0C, 32'h0000_0081);
        rd(FLG, ONE);
        wr(FLG | 8'h08, 32'h0000_0024);
        wr(FLG | 8'h04, 32'h0000_0005);
        rd(FLG, 32'h0000_0020);
        wr(MEN, 32'hFFFF_FFFF);
        rd(MEN, 32'h0000_0002);
        wr(MEN | 8'h0C, 32'h0000_0002);
        rd(MEN, ZERO);
        // Event and clear in one cycle: the event must survive
        fork
            wr(FLG, 32'h0000_00A0);
            usb_err_source_i.fire(8'h80, 1'b0);
        join
        rd(FLG, 32'h0000_0080);
        $display("test alias set done");
        wr(MSK, FF);
        wr(MEN, 32'h0000_0002);
        @(posedge clk_i);
        rst_i <= 1'b1;
        #1 cmp(32'(irq_o), ONE);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 cmp(32'(irq_o), ZERO);
        rd(MSK, ZERO);
        rd(FLG, ZERO);
        rd(MEN, ZERO);
        $display("test reset again done");
        repeat (8) begin
            r = $urandom();
            wr(FLG, FF);
            wr(MSK, r);
            usb_err_source_i.fire(r[15:8], 1'b0);
            #1 cmp(32'(combined_err_o), 32'(|(r[15:8] & r[7:0])));
            cmp(32'(err_flag_o), {24'h00_0000, r[15:8]});
            rd(FLG, {24'h00_0000, r[15:8]});
        end
        $display("test random done");
        repeat (3) @(posedge clk_i);
        close_out();
    end
    // Whole run is well under ten thousand cycles
    initial begin
        #200_000;
        bad_count++;
        close_out();
    end
endmodule
